// file: common/pcs_defines.svh
// constants for the program sequencing and indirect addressing block
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_PC_W        13
`define PCS_STACK_DEPTH 8
`define PCS_SP_W        3
`define PCS_ADDR_W      9
`define PCS_JUMP_W      11
`define PCS_PC_RESET    13'h0000
`define PCS_SP_RESET    3'h0
`define PCS_BYTE_ZERO   8'h00
`define PCS_SP_ONE      3'h1
`define PCS_WINDOW_ADDR 7'h00
`define PCS_WINDOW_REG  9'h000
`define PCS_PC_ONE      13'h0001
`define PCS_MATCH_HI    6
`define PCS_LATCH_HI    4
`define PCS_LATCH_CALL  3
`define PCS_BYTE_HI     7
`define PCS_IRP_BIT     7
`define PCS_REG_PCLOW   9'h002
`define PCS_REG_PTR     9'h004
`define PCS_REG_LATCH   9'h00a
`define PCS_REG_STATUS  9'h003
`endif

// file: common/pcs_pkg.sv
// types for the program sequencing and indirect addressing block
package pcs_pkg;
  // sequencing request from instruction decode
  typedef enum logic [5:0] {
    PCS_OP_NONE   = 6'h01,
    PCS_OP_STEP   = 6'h02,
    PCS_OP_JUMP   = 6'h04,
    PCS_OP_CALL   = 6'h08,
    PCS_OP_RETURN = 6'h10,
    PCS_OP_INTR   = 6'h20
  } pcs_op_t;
  typedef struct packed {
    pcs_op_t     op;
    logic [10:0] target;   // call/goto address field
    logic [12:0] vector;   // interrupt vector address
  } pcs_seq_req_t;
  // data-space access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;      // direct bank-resolved address
    logic [7:0] wdata;
  } pcs_acc_t;
  // forwarded access to data memory
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pcs_mem_t;
endpackage

// file: rtl/pcs_stack.sv
// 8-entry circular return stack
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_stack (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // push and pop
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [12:0] push_pc,
  output logic      [12:0] top_pc
);
  import pcs_pkg::*;
  typedef struct packed {
    logic [`PCS_STACK_DEPTH-1:0][`PCS_PC_W-1:0] mem;
    logic [`PCS_SP_W-1:0]                       sp;
  } pcs_stack_state_t;
  pcs_stack_state_t st;
  pcs_stack_state_t next_st;
  // pointer wraps silently, nothing reports overflow or underflow
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.sp] = push_pc;
      next_st.sp = st.sp + `PCS_SP_ONE;
    end else if (pop) begin
      next_st.sp = st.sp - `PCS_SP_ONE;
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st.sp  <= `PCS_SP_RESET;
      st.mem <= st.mem;
    end else begin
      st <= next_st;
    end
  end
  // entry below the pointer is the most recent push
  assign top_pc = st.mem[st.sp - `PCS_SP_ONE];
endmodule // pcs_stack

// file: rtl/pcs_indirect.sv
// indirect address former
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_indirect (
  // pointer and bank
  input  wire logic [7:0] pointer,
  input  wire logic       bank_select,
  // formed address
  output logic      [8:0] ind_addr,
  output logic            self_ref
);
  import pcs_pkg::*;
  // bank bit on top of the pointer
  assign ind_addr = {bank_select, pointer};
  // pointer naming the window again
  assign self_ref = (pointer[`PCS_MATCH_HI:0] == `PCS_WINDOW_ADDR);
endmodule // pcs_indirect

// file: rtl/pcs_top.sv
// program counter, return stack and indirect access
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_top (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // sequencing from decode
  input  pcs_pkg::pcs_seq_req_t   seq_req,
  output logic [12:0]             pc,
  // data access from the core
  input  pcs_pkg::pcs_acc_t       acc,
  output logic [7:0]              rdata,
  output logic                    rdata_valid,
  // data memory side
  output pcs_pkg::pcs_mem_t       mem_req,
  input  wire logic [7:0]         mem_rdata,
  // status register bit from the core
  input  wire logic [7:0]         status_reg,
  // block-held registers seen by the core
  output logic [7:0]              pc_high_holding_latch,
  output logic [7:0]              indirect_pointer
);
  import pcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  latch;
    logic [7:0]  pointer;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        from_mem;
  } pcs_top_state_t;
  pcs_top_state_t st;
  pcs_top_state_t next_st;

  logic        push;
  logic        pop;
  logic [12:0] top_pc;
  logic [8:0]  ind_addr;
  logic        self_ref;
  logic        hit_window;
  logic        self_hit;
  logic [8:0]  eff_addr;

  // returns true when a bank-resolved address names a given register
  function automatic logic reg_hit(input logic [8:0] a, input logic [8:0] r);
    reg_hit = (a[`PCS_MATCH_HI:0] == r[`PCS_MATCH_HI:0]);
  endfunction

  // low byte write: five latch bits fill the upper counter bits
  function automatic logic [12:0] low_load(input logic [7:0] latch, input logic [7:0] b);
    low_load = {latch[`PCS_LATCH_HI:0], b};
  endfunction

  // call and goto: two latch bits above the eleven-bit field
  function automatic logic [12:0] far_load(input logic [7:0] latch, input logic [10:0] t);
    far_load = {latch[`PCS_LATCH_HI:`PCS_LATCH_CALL], t};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  pcs_stack u_stack (
    .clk     (clk),
    .rst     (rst),
    .push    (push),
    .pop     (pop),
    .push_pc (st.pc),
    .top_pc  (top_pc)
  );

  pcs_indirect u_ind (
    .pointer     (st.pointer),
    .bank_select (status_reg[`PCS_IRP_BIT]),
    .ind_addr    (ind_addr),
    .self_ref    (self_ref)
  );

  // stack actions from the sequencing request
  assign push = (seq_req.op == PCS_OP_CALL) || (seq_req.op == PCS_OP_INTR);
  assign pop  = (seq_req.op == PCS_OP_RETURN);
  assign hit_window = reg_hit(acc.addr, `PCS_WINDOW_REG);
  // window self-reference and the address every access resolves to
  assign self_hit   = hit_window && self_ref;
  assign eff_addr   = hit_window ? ind_addr : acc.addr;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st          = st;
    next_st.rvalid   = acc.rd;
    next_st.from_mem = 1'b0;
    next_st.rdata    = `PCS_BYTE_ZERO;
    // program counter sequencing, latch untouched by stack moves
    case (seq_req.op)
      PCS_OP_STEP:   next_st.pc = st.pc + `PCS_PC_ONE;
      PCS_OP_JUMP,
      PCS_OP_CALL:   next_st.pc = far_load(st.latch, seq_req.target);
      PCS_OP_RETURN: next_st.pc = top_pc;
      PCS_OP_INTR:   next_st.pc = seq_req.vector;
      default:       next_st.pc = st.pc;
    endcase
    // register writes; a self-pointing window write stores nothing
    if (acc.wr && !self_hit) begin
      if (reg_hit(eff_addr, `PCS_REG_PCLOW)) begin
        next_st.pc = low_load(st.latch, acc.wdata);
      end else if (reg_hit(eff_addr, `PCS_REG_PTR)) begin
        next_st.pointer = acc.wdata;
      end else if (reg_hit(eff_addr, `PCS_REG_LATCH)) begin
        next_st.latch = acc.wdata;
      end
    end
    // register reads; self-pointing window answers zero
    if (acc.rd) begin
      if (self_hit) begin
        next_st.rdata = `PCS_BYTE_ZERO;
      end else if (reg_hit(eff_addr, `PCS_REG_PCLOW)) begin
        next_st.rdata = st.pc[`PCS_BYTE_HI:0];
      end else if (reg_hit(eff_addr, `PCS_REG_PTR)) begin
        next_st.rdata = st.pointer;
      end else if (reg_hit(eff_addr, `PCS_REG_LATCH)) begin
        next_st.rdata = st.latch;
      end else begin
        next_st.from_mem = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st.pc       <= `PCS_PC_RESET;
      st.latch    <= `PCS_BYTE_ZERO;
      st.pointer  <= `PCS_BYTE_ZERO;
      st.rdata    <= `PCS_BYTE_ZERO;
      st.rvalid   <= 1'b0;
      st.from_mem <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory forwarding, window redirected through the pointer
  always_comb begin
    mem_req.addr  = eff_addr;
    mem_req.wdata = acc.wdata;
    mem_req.rd    = acc.rd && !self_hit;
    mem_req.wr    = acc.wr && !self_hit;
  end

  // outputs
  assign pc                    = st.pc;
  assign rdata                 = st.from_mem ? mem_rdata : st.rdata;
  assign rdata_valid           = st.rvalid;
  assign pc_high_holding_latch = st.latch;
  assign indirect_pointer      = st.pointer;
endmodule // pcs_top

// file: tb/pcs_sva.sv
// checker for the sequencing and indirect access block
`timescale 1ns/1ps
module pcs_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // watched ports
  input pcs_pkg::pcs_seq_req_t seq_req,
  input wire logic [12:0] pc,
  input pcs_pkg::pcs_acc_t     acc,
  input wire logic [7:0]  rdata,
  input pcs_pkg::pcs_mem_t     mem_req,
  input wire logic [7:0]  pc_high_holding_latch,
  input wire logic [7:0]  indirect_pointer
);
  import pcs_pkg::*;
  logic pcw;
  logic self;
  // low-byte write and self-pointing window
  assign pcw = acc.wr && acc.addr[6:0] == 7'h02;
  assign self = acc.addr[6:0] == 7'h00 && indirect_pointer[6:0] == 7'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence call_s; seq_req.op == PCS_OP_CALL && !pcw; endsequence
  sequence ret_s; seq_req.op == PCS_OP_RETURN && !pcw; endsequence
  reset_clear_a: assert property ($fell(rst) |-> pc == 13'h0000)
    else $error("pc not cleared");
  low_load_a: assert property (pcw |=> pc == {$past(pc_high_holding_latch[4:0]), $past(acc.wdata)})
    else $error("low byte load wrong");
  call_target_a: assert property (call_s |=> pc == {$past(pc_high_holding_latch[4:3]), $past(seq_req.target)})
    else $error("call target wrong");
  intr_vector_a: assert property (seq_req.op == PCS_OP_INTR && !pcw |=> pc == $past(seq_req.vector))
    else $error("vector not taken");
  call_return_a: assert property (call_s ##1 ret_s |=> pc == $past(pc, 2))
    else $error("return address wrong");
  latch_kept_a: assert property (seq_req.op inside {PCS_OP_CALL, PCS_OP_RETURN, PCS_OP_INTR} && !acc.wr |=> $stable(pc_high_holding_latch))
    else $error("latch moved");
  low_read_a: assert property (acc.rd && acc.addr[6:0] == 7'h02 |=> rdata == $past(pc[7:0]))
    else $error("low byte read wrong");
  self_zero_a: assert property (acc.rd && self |=> rdata == 8'h00)
    else $error("self read not zero");
  self_nowrite_a: assert property (acc.wr && self |-> !mem_req.wr)
    else $error("self write stored");
endmodule // pcs_sva
bind pcs_top pcs_sva u_sva (.clk, .rst, .seq_req, .pc, .acc, .rdata, .mem_req,
  .pc_high_holding_latch, .indirect_pointer);

// file: tb/pcs_mem_model.sv
// data memory behind the block
`timescale 1ns/1ps
module pcs_mem_model (
  // clock
  input wire logic        clk,
  // request and answer
  input pcs_pkg::pcs_mem_t mem_req,
  output logic [7:0]      mem_rdata
);
  import pcs_pkg::*;
  logic [7:0] mem [512];
  initial mem_rdata = 8'h00;
  // answer a cycle later, otherwise a changing pattern
  always @(posedge clk) begin
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
  end
endmodule // pcs_mem_model

// file: tb/tb.sv
// self-checking bench for the sequencing and indirect access block
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcs_seq_req_t seq_req = '{PCS_OP_NONE, 11'h000, 13'h0000};
  pcs_acc_t acc = '0;
  logic [7:0] status_reg = 8'h00;
  logic [12:0] pc, m_pc, stk [8], pq [$], rq [$];
  logic [7:0] rdata, mem_rdata, lat, ptr, d, lat_o, ptr_o, xl, xp;
  logic rdata_valid, due, vexp;
  pcs_mem_t mem_req;
  logic [2:0] sp;
  logic [31:0] seed = 32'd67679;
  int n_fail = 0;
  int checks_done = 0;
  pcs_top dut (.clk, .rst, .seq_req, .pc, .acc, .rdata, .rdata_valid, .mem_req, .mem_rdata,
    .status_reg, .pc_high_holding_latch(lat_o), .indirect_pointer(ptr_o));
  pcs_mem_model u_mem (.clk, .mem_req, .mem_rdata);
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(pcs_op_t o, logic [10:0] t, logic [12:0] v, logic w, logic r,
                     logic [8:0] a, logic [7:0] x);
    seq_req <= '{o, t, v};
    acc <= '{w, r, a, x};
    @(posedge clk);
  endtask
  task automatic idle();
    cyc(PCS_OP_NONE, 11'h0, 13'h0, 1'b0, 1'b0, 9'h0, 8'h0);
  endtask
  // model the counter and circular stack, then issue
  task automatic go(pcs_op_t o, logic [10:0] t, logic [12:0] v);
    if (o == PCS_OP_CALL || o == PCS_OP_INTR) begin
      stk[sp] = m_pc;
      sp = sp + 3'h1;
    end
    if (o == PCS_OP_RETURN) begin
      sp = sp - 3'h1;
      m_pc = stk[sp];
    end
    else if (o == PCS_OP_STEP) m_pc = m_pc + 13'h1;
    else m_pc = (o == PCS_OP_INTR) ? v : {lat[4:3], t};
    pq.push_back(m_pc);
    cyc(o, t, v, 1'b0, 1'b0, 9'h0, 8'h0);
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] x);
    if (a[6:0] == 7'h0a) lat = x;
    if (a[6:0] == 7'h04) ptr = x;
    if (a[6:0] == 7'h02) begin
      m_pc = {lat[4:0], x};
      pq.push_back(m_pc);
    end
    cyc(PCS_OP_NONE, 11'h0, 13'h0, 1'b1, 1'b0, a, x);
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] e);
    rq.push_back({5'h0, e});
    cyc(PCS_OP_NONE, 11'h0, 13'h0, 1'b0, 1'b1, a, 8'h0);
  endtask
  task automatic cmp(string nm, logic [12:0] e, logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    cmp("queue", 13'h0, 13'(pq.size() + rq.size()));
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare each result against the oldest note; shadow the two registers
  always @(posedge clk) begin
    due = !rst && (seq_req.op !== PCS_OP_NONE || (acc.wr && acc.addr[6:0] == 7'h02));
    vexp = !rst && acc.rd;
    if (rst) {xl, xp} = '0;
    else if (acc.wr && acc.addr[6:0] == 7'h0a) xl = acc.wdata;
    else if (acc.wr && acc.addr[6:0] == 7'h04) xp = acc.wdata;
    #1;
    if (due) cmp("pc", pq.pop_front(), pc);
    cmp("rdata_valid", 13'(vexp), 13'(rdata_valid));
    if (vexp) cmp("rdata", rq.pop_front(), {5'h0, rdata});
    cmp("latch", {5'h0, xl}, {5'h0, lat_o});
    cmp("pointer", {5'h0, xp}, {5'h0, ptr_o});
  end
  initial begin
    repeat (500) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    {m_pc, sp, lat, ptr} = '0;
    rd(9'h002, 8'h00);
    wr(9'h00a, 8'(rnd()));
    wr(9'h002, 8'(rnd()));
    rd(9'h002, m_pc[7:0]);
    for (int i = 0; i < 10; i++) go(PCS_OP_CALL, 11'(rnd()), 13'h0);
    rd(9'h00a, lat);
    for (int i = 0; i < 11; i++) go(PCS_OP_RETURN, 11'h0, 13'h0);
    go(PCS_OP_INTR, 11'h0, 13'(rnd()));
    go(PCS_OP_STEP, 11'h0, 13'h0);
    go(PCS_OP_JUMP, 11'(rnd()), 13'h0);
    go(PCS_OP_RETURN, 11'h0, 13'h0);
    for (int b = 0; b < 2; b++) begin
      status_reg <= {b[0], 7'(rnd())};
      d = 8'(rnd());
      wr(9'h004, {1'(rnd()), 3'h3, 4'(rnd())});
      rd(9'h004, ptr);
      wr(9'h000, d);
      rd(9'h000, d);
      rd({b[0], ptr}, d);
    end
    wr(9'h004, 8'h80);
    wr(9'h100, 8'h5a);
    rd(9'h000, 8'h00);
    rst <= 1'b1;
    idle();
    rst <= 1'b0;
    {m_pc, sp, lat, ptr} = '0;
    go(PCS_OP_CALL, 11'h7ff, 13'h0);
    go(PCS_OP_RETURN, 11'h0, 13'h0);
    repeat (2) idle();
    conclude();
  end
endmodule // tb
